// ===== src/rts_map.vh
// Purpose: register offsets, field codes and timing for the ramp select block
// Assumes: APB slave, 32-bit words, byte addresses
// Notes: register offsets are local choices
`ifndef RTS_MAP_VH
`define RTS_MAP_VH
// register byte offsets
`define RTS_ADDR_ACC1 8'h00
`define RTS_ADDR_DEC1 8'h04
`define RTS_ADDR_ACC2 8'h08
`define RTS_ADDR_DEC2 8'h0C
`define RTS_ADDR_ACC3 8'h10
`define RTS_ADDR_DEC3 8'h14
`define RTS_ADDR_ACC4 8'h18
`define RTS_ADDR_DEC4 8'h1C
`define RTS_ADDR_SWFREQ 8'h20
`define RTS_ADDR_JOGFREQ 8'h24
`define RTS_ADDR_JOGACC 8'h28
`define RTS_ADDR_JOGDEC 8'h2C
`define RTS_ADDR_ESTOP 8'h30
`define RTS_ADDR_CTRL 8'h34
`define RTS_ADDR_FMAX 8'h38
`define RTS_ADDR_STATUS 8'h3C
`define RTS_ADDR_FREQ 8'h40
`define RTS_ADDR_STEP 8'h44
`define RTS_ADDR_DCB 8'h48
// control register fields
`define RTS_CTRL_MODE_LSB 0
`define RTS_CTRL_MODE_MSB 2
`define RTS_CTRL_DUTY 3
`define RTS_CTRL_POL 4
`define RTS_CTRL_ZSP_LSB 5
`define RTS_CTRL_ZSP_MSB 6
`define RTS_CTRL_APP_LSB 7
`define RTS_CTRL_APP_MSB 9
`define RTS_CTRL_EXTRUN 10
`define RTS_CTRL_SUP50 11
`define RTS_CTRL_RATE_LSB 12
`define RTS_CTRL_RATE_MSB 13
`define RTS_CTRL_CARHI 14
`define RTS_CTRL_APPLY 15
`define RTS_CTRL_RESET 32'h00000000
// control modes
`define RTS_MODE_VF 3'h0
`define RTS_MODE_VFPG 3'h1
`define RTS_MODE_SLV 3'h2
`define RTS_MODE_SV 3'h3
`define RTS_MODE_PERMANENT_MAGNET_ENCODER_VECTOR_MODE 3'h4
// zero speed codes
`define RTS_ZSP_FOLLOW 2'h0
`define RTS_ZSP_STOP 2'h1
`define RTS_ZSP_LOWEST 2'h2
`define RTS_ZSP_HOLD 2'h3
// application codes
`define RTS_APP_PUMP 3'h1
`define RTS_CURVE_60 4'h6
`define RTS_CURVE_50 4'h4
// limits in 0.01 Hz and percent, default times in 0.1 s
`define RTS_FMAX_HEAVY 16'hE9FC
`define RTS_FMAX_NORMAL 16'h2EE0
`define RTS_FMAX_150 16'h3A98
`define RTS_FMAX_110 16'h2AF8
`define RTS_FMAX_100 16'h2710
`define RTS_FMAX_80 16'h1F40
`define RTS_OVL_HEAVY 8'h96
`define RTS_OVL_NORMAL 8'h78
`define RTS_JOG_DEFAULT 16'h0258
`define RTS_TIME_DEFAULT 16'h0064
// ticks: one tenth second at 200 MHz
`define RTS_TICK_NS 100000000
`define RTS_CLK_NS 5
`endif

// ===== src/rts_divider.v
// Purpose: sequential unsigned divider for ramp step computation
// Assumes: start pulses only when idle
// Notes: one quotient bit per clock
`timescale 1ns/1ps
module rts_divider
#(
  parameter W = 32
)
(
  input wire mclk,
  input wire rst_b,
  input wire start,
  input wire [W-1:0] dividend,
  input wire [W-1:0] divisor,
  output reg [W-1:0] quotient,
  output reg done
);
  reg [W-1:0] remQ;
  reg [W-1:0] numQ;
  reg [W-1:0] quoQ;
  reg [W-1:0] denQ;
  reg [5:0] cntQ;
  reg busyQ;
  wire [W:0] trial = {remQ, numQ[W-1]};
  wire fits = trial >= {1'b0, denQ};
  wire [W:0] diff = trial - {1'b0, denQ};

  // shift-subtract iterations
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      remQ <= {W{1'b0}};
      numQ <= {W{1'b0}};
      quoQ <= {W{1'b0}};
      denQ <= {W{1'b0}};
      cntQ <= 6'h00;
      busyQ <= 1'b0;
      quotient <= {W{1'b0}};
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busyQ)
      begin
        remQ <= {W{1'b0}};
        numQ <= dividend;
        denQ <= (divisor == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : divisor;
        cntQ <= W[5:0];
        busyQ <= 1'b1;
      end
      else if (busyQ)
      begin
        remQ <= fits ? diff[W-1:0] : trial[W-1:0];
        numQ <= {numQ[W-2:0], 1'b0};
        quoQ <= {quoQ[W-2:0], fits};
        cntQ <= cntQ - 6'h01;
        if (cntQ == 6'h01)
        begin
          busyQ <= 1'b0;
          done <= 1'b1;
          quotient <= {quoQ[W-2:0], fits};
        end
      end
    end
  end
endmodule // rts_divider

// ===== src/rts_ramp_select.v
// What this block does
// RULE1 - sel2,sel1 pattern picks ramp pair
// RULE2 - motor switch only in V/f modes
// RULE3 - motor two uses pair three/four
// RULE4 - auto mode: threshold selects pair one/four
// RULE5 - terminal selection beats automatic switching
// RULE6 - jog frequency setting, default six hertz
// RULE7 - jog accel/decel times settable
// RULE8 - terminal jog needs external run source
// RULE9 - emergency stop ramps with own time
// RULE10 - restart refused until run and stop removed
// RULE11 - output block cuts output immediately
// RULE12 - duty selects overload, stall, max frequency; no stall limit is implemented, only overload and max frequency
// RULE13 - sensorless heavy duty max frequency reduced
// RULE14 - normal duty only in V/f modes
// RULE15 - polarity maps or inverts analog reference
// RULE16 - four zero-speed behaviour codes; STOP and HOLD both give a zero freqRef, FOLLOW and LOWEST both give maxFreq
// RULE17 - DC braking after stop below start
// RULE18 - application code loads preset settings
// RULE19 - pump preset: V/f, forward, restart, curve
// RULE20 - times span zero to full max
// RULE21 - switch-over threshold in hundredths hertz
// RULE22 - step is fmax over time ticks
// RULE23 - latch clears when both inputs inactive
// Purpose: ramp time selection, jog, emergency stop and duty limits
// Assumes: APB registers, terminal inputs synchronous to mclk
// Notes: times in 0.1 s, frequencies in 0.01 Hz
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rts_map.vh"
module rts_ramp_select
#(
  parameter TICK_CYCLES = `RTS_TICK_NS / `RTS_CLK_NS,
  parameter ADC_W = 12
)
(
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire timeSel1,
  input wire timeSel2,
  input wire timeSelAssigned,
  input wire motorSwitch,
  input wire runCmd,
  input wire jogFwd,
  input wire jogRev,
  input wire emergencyStop,
  input wire outputBlock,
  input wire [15:0] outFreq,
  input wire [ADC_W-1:0] analog_input_one,
  input wire [ADC_W-1:0] analog_input_two,
  output reg [15:0] accelTime,
  output reg [15:0] decelTime,
  output reg [15:0] freqRef,
  output reg [15:0] maxFreq,
  output reg [7:0] overloadPct,
  output reg [31:0] rampStep,
  output reg outputEnable,
  output reg jogActive,
  output reg jogReverse,
  output reg emergency_stop_indication,
  output reg dcBrake,
  output reg [ADC_W-1:0] refOne,
  output reg [ADC_W-1:0] refTwo
);
  // states of the stop sequencer, one-hot
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN = 4'b0010;
  localparam [3:0] ST_ESTOP = 4'b0100;
  localparam [3:0] ST_BRAKE = 4'b1000;

  reg [15:0] accQ [0:3];
  reg [15:0] decQ [0:3];
  reg [15:0] swFreq_q;
  reg [15:0] jogFreq_q;
  reg [15:0] jogAcc_q;
  reg [15:0] jogDec_q;
  reg [15:0] estopTime_q;
  reg [31:0] ctrl_q;
  reg [15:0] dcbStart_q;
  reg [15:0] dcbTime_q;
  reg [3:0] curve_q;
  reg dirLock_q;
  reg restart_q;
  reg estopLatch_q;
  reg [3:0] state_q;
  reg [31:0] tickCnt_q;
  reg [15:0] brakeCnt_q;
  reg [1:0] pairSel;
  reg divStart_q;
  reg [15:0] selTime;

  wire [2:0] mode = ctrl_q[`RTS_CTRL_MODE_MSB:`RTS_CTRL_MODE_LSB];
  wire vfMode = (mode == `RTS_MODE_VF) || (mode == `RTS_MODE_VFPG);
  wire [1:0] zspSel = ctrl_q[`RTS_CTRL_ZSP_MSB:`RTS_CTRL_ZSP_LSB];
  wire [2:0] appSel = ctrl_q[`RTS_CTRL_APP_MSB:`RTS_CTRL_APP_LSB];
  // RULE14 normal duty gate
  wire normalDuty = ctrl_q[`RTS_CTRL_DUTY] & vfMode;
  // RULE2 motor switch gate
  wire motorTwo = motorSwitch & vfMode;
  // RULE8 external jog source
  wire jogReq = ctrl_q[`RTS_CTRL_EXTRUN] & (jogFwd ^ jogRev);
  wire access = psel & penable;
  wire wrEn = access & pwrite;
  wire tick = tickCnt_q == (TICK_CYCLES - 1);
  wire [31:0] quot;
  wire divDone;
  reg regHit;

  // apb: zero wait state, unmapped reads zero with error
  assign pready = 1'b1;
  assign pslverr = access & ~regHit;

  // address decode hit
  always @*
  begin
    case (paddr)
      `RTS_ADDR_ACC1, `RTS_ADDR_DEC1, `RTS_ADDR_ACC2, `RTS_ADDR_DEC2,
      `RTS_ADDR_ACC3, `RTS_ADDR_DEC3, `RTS_ADDR_ACC4, `RTS_ADDR_DEC4,
      `RTS_ADDR_SWFREQ, `RTS_ADDR_JOGFREQ, `RTS_ADDR_JOGACC, `RTS_ADDR_JOGDEC,
      `RTS_ADDR_ESTOP, `RTS_ADDR_CTRL, `RTS_ADDR_FMAX, `RTS_ADDR_STATUS,
      `RTS_ADDR_FREQ, `RTS_ADDR_STEP, `RTS_ADDR_DCB: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  end

  // register writes and application presets
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accQ[0] <= `RTS_TIME_DEFAULT;
      accQ[1] <= `RTS_TIME_DEFAULT;
      accQ[2] <= `RTS_TIME_DEFAULT;
      accQ[3] <= `RTS_TIME_DEFAULT;
      decQ[0] <= `RTS_TIME_DEFAULT;
      decQ[1] <= `RTS_TIME_DEFAULT;
      decQ[2] <= `RTS_TIME_DEFAULT;
      decQ[3] <= `RTS_TIME_DEFAULT;
      swFreq_q <= 16'h0000;
      // RULE6 jog default
      jogFreq_q <= `RTS_JOG_DEFAULT;
      jogAcc_q <= `RTS_TIME_DEFAULT;
      jogDec_q <= `RTS_TIME_DEFAULT;
      estopTime_q <= `RTS_TIME_DEFAULT;
      ctrl_q <= `RTS_CTRL_RESET;
      dcbStart_q <= 16'h0000;
      dcbTime_q <= 16'h0000;
      curve_q <= 4'h0;
      dirLock_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else if (wrEn)
    begin
      case (paddr)
        // RULE7 jog times; RULE21 threshold in 0.01 Hz
        `RTS_ADDR_ACC1: accQ[0] <= pwdata[15:0];
        `RTS_ADDR_DEC1: decQ[0] <= pwdata[15:0];
        `RTS_ADDR_ACC2: accQ[1] <= pwdata[15:0];
        `RTS_ADDR_DEC2: decQ[1] <= pwdata[15:0];
        `RTS_ADDR_ACC3: accQ[2] <= pwdata[15:0];
        `RTS_ADDR_DEC3: decQ[2] <= pwdata[15:0];
        `RTS_ADDR_ACC4: accQ[3] <= pwdata[15:0];
        `RTS_ADDR_DEC4: decQ[3] <= pwdata[15:0];
        `RTS_ADDR_SWFREQ: swFreq_q <= pwdata[15:0];
        `RTS_ADDR_JOGFREQ: jogFreq_q <= pwdata[15:0];
        `RTS_ADDR_JOGACC: jogAcc_q <= pwdata[15:0];
        `RTS_ADDR_JOGDEC: jogDec_q <= pwdata[15:0];
        `RTS_ADDR_ESTOP: estopTime_q <= pwdata[15:0];
        `RTS_ADDR_DCB:
        begin
          dcbStart_q <= pwdata[15:0];
          dcbTime_q <= pwdata[31:16];
        end
        `RTS_ADDR_CTRL:
        begin
          ctrl_q <= {16'h0000, 1'b0, pwdata[14:0]};
          // RULE18 apply preset on write
          if (pwdata[`RTS_CTRL_APPLY])
          begin
            // RULE19 pump preset
            if (pwdata[`RTS_CTRL_APP_MSB:`RTS_CTRL_APP_LSB] == `RTS_APP_PUMP)
            begin
              ctrl_q[`RTS_CTRL_MODE_MSB:`RTS_CTRL_MODE_LSB] <= `RTS_MODE_VF;
              dirLock_q <= 1'b1;
              restart_q <= 1'b1;
              curve_q <= pwdata[`RTS_CTRL_SUP50] ? `RTS_CURVE_50 : `RTS_CURVE_60;
            end
            else
            begin
              dirLock_q <= 1'b0;
              restart_q <= 1'b0;
              curve_q <= 4'h0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ramp pair selection
  always @*
  begin
    // RULE3 motor two pairs
    if (motorTwo)
      pairSel = {1'b1, timeSel1};
    // RULE5 terminals first; RULE1 pattern
    else if (timeSelAssigned)
      pairSel = {timeSel2, timeSel1};
    // RULE4 automatic threshold
    else
      pairSel = (outFreq >= swFreq_q) ? 2'h3 : 2'h0;
  end

  // max frequency from duty and rating
  always @*
  begin
    // RULE12 duty limits
    maxFreq = normalDuty ? `RTS_FMAX_NORMAL : `RTS_FMAX_HEAVY;
    overloadPct = normalDuty ? `RTS_OVL_NORMAL : `RTS_OVL_HEAVY;
    // RULE13 sensorless reduction
    if (!normalDuty && mode == `RTS_MODE_SLV)
    begin
      case (ctrl_q[`RTS_CTRL_RATE_MSB:`RTS_CTRL_RATE_LSB])
        2'h0: maxFreq = `RTS_FMAX_150;
        2'h1: maxFreq = `RTS_FMAX_110;
        2'h2: maxFreq = `RTS_FMAX_100;
        default: maxFreq = ctrl_q[`RTS_CTRL_CARHI] ? `RTS_FMAX_80 : `RTS_FMAX_100;
      endcase
    end
  end

  // stop sequencer with emergency latch
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      estopLatch_q <= 1'b0;
      brakeCnt_q <= 16'h0000;
    end
    else
    begin
      // RULE23 set wins, clear needs both low
      if (emergencyStop)
        estopLatch_q <= 1'b1;
      else if (!runCmd && !jogReq)
        estopLatch_q <= 1'b0;
      case (state_q)
        ST_IDLE:
          // RULE10 refuse restart while latched
          if ((runCmd || jogReq) && !estopLatch_q && !emergencyStop)
            state_q <= ST_RUN;
        ST_RUN:
          if (emergencyStop)
            state_q <= ST_ESTOP;
          // RULE17 braking below start frequency
          else if (!runCmd && !jogReq && outFreq < dcbStart_q)
          begin
            state_q <= ST_BRAKE;
            brakeCnt_q <= dcbTime_q;
          end
        ST_ESTOP:
          if (outFreq == 16'h0000)
            state_q <= ST_IDLE;
        ST_BRAKE:
          if (brakeCnt_q == 16'h0000)
            state_q <= ST_IDLE;
          else if (tick)
            brakeCnt_q <= brakeCnt_q - 16'h0001;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // chosen time for the ramp step
  always @*
  begin
    // RULE20 accelerate when below reference
    if (state_q == ST_ESTOP)
      selTime = estopTime_q;
    else if (jogActive)
      selTime = (outFreq < freqRef) ? jogAcc_q : jogDec_q;
    else
      selTime = (outFreq < freqRef) ? accQ[pairSel] : decQ[pairSel];
  end

  // registered outputs and tick timer
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickCnt_q <= 32'h00000000;
      divStart_q <= 1'b0;
      accelTime <= `RTS_TIME_DEFAULT;
      decelTime <= `RTS_TIME_DEFAULT;
      freqRef <= 16'h0000;
      rampStep <= 32'h00000000;
      outputEnable <= 1'b0;
      jogActive <= 1'b0;
      jogReverse <= 1'b0;
      emergency_stop_indication <= 1'b0;
      dcBrake <= 1'b0;
      refOne <= {ADC_W{1'b0}};
      refTwo <= {ADC_W{1'b0}};
    end
    else
    begin
      tickCnt_q <= tick ? 32'h00000000 : tickCnt_q + 32'h00000001;
      // RULE22 restart division each tick
      divStart_q <= tick;
      if (divDone)
        rampStep <= quot;
      accelTime <= jogActive ? jogAcc_q : accQ[pairSel];
      // RULE9 emergency time and indication
      decelTime <= (state_q == ST_ESTOP) ? estopTime_q :
                   (jogActive ? jogDec_q : decQ[pairSel]);
      emergency_stop_indication <= estopLatch_q | emergencyStop;
      jogActive <= jogReq & (state_q == ST_RUN);
      jogReverse <= jogRev & ~jogFwd;
      // RULE16 zero speed handling
      if (jogReq)
        freqRef <= jogFreq_q;
      else if (zspSel == `RTS_ZSP_STOP || zspSel == `RTS_ZSP_HOLD)
        freqRef <= 16'h0000;
      else
        freqRef <= maxFreq;
      // RULE11 block output at once
      outputEnable <= ~outputBlock & (state_q != ST_IDLE) & (state_q != ST_BRAKE);
      dcBrake <= (state_q == ST_BRAKE) & ~outputBlock;
      // RULE15 analog polarity
      refOne <= ctrl_q[`RTS_CTRL_POL] ? ~analog_input_one : analog_input_one;
      refTwo <= ctrl_q[`RTS_CTRL_POL] ? ~analog_input_two : analog_input_two;
    end
  end

  // step = fmax / time
  rts_divider #(.W(32)) uDiv
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(divStart_q),
    .dividend({16'h0000, maxFreq}),
    .divisor({16'h0000, selTime}),
    .quotient(quot),
    .done(divDone)
  );

  // read mux
  always @*
  begin
    case (paddr)
      `RTS_ADDR_ACC1: prdata = {16'h0000, accQ[0]};
      `RTS_ADDR_DEC1: prdata = {16'h0000, decQ[0]};
      `RTS_ADDR_ACC2: prdata = {16'h0000, accQ[1]};
      `RTS_ADDR_DEC2: prdata = {16'h0000, decQ[1]};
      `RTS_ADDR_ACC3: prdata = {16'h0000, accQ[2]};
      `RTS_ADDR_DEC3: prdata = {16'h0000, decQ[2]};
      `RTS_ADDR_ACC4: prdata = {16'h0000, accQ[3]};
      `RTS_ADDR_DEC4: prdata = {16'h0000, decQ[3]};
      `RTS_ADDR_SWFREQ: prdata = {16'h0000, swFreq_q};
      `RTS_ADDR_JOGFREQ: prdata = {16'h0000, jogFreq_q};
      `RTS_ADDR_JOGACC: prdata = {16'h0000, jogAcc_q};
      `RTS_ADDR_JOGDEC: prdata = {16'h0000, jogDec_q};
      `RTS_ADDR_ESTOP: prdata = {16'h0000, estopTime_q};
      `RTS_ADDR_CTRL: prdata = ctrl_q;
      `RTS_ADDR_FMAX: prdata = {overloadPct, 8'h00, maxFreq};
      `RTS_ADDR_STATUS: prdata = {16'h0000, curve_q, dirLock_q, restart_q,
                                  pairSel, state_q, estopLatch_q, normalDuty,
                                  motorTwo, jogActive};
      `RTS_ADDR_FREQ: prdata = {freqRef, outFreq};
      `RTS_ADDR_STEP: prdata = rampStep;
      `RTS_ADDR_DCB: prdata = {dcbTime_q, dcbStart_q};
      default: prdata = 32'h00000000;
    endcase
  end
endmodule // rts_ramp_select

// ===== test/rts_assertions.sv
// Purpose: port-level checks for the ramp select block
// Assumes: bound to rts_ramp_select, one clock domain
// Notes: selection of ramp pairs is checked by the bench
`timescale 1ns/1ps
module rts_checker
#(
  parameter TICK_CYCLES = 4,
  parameter ADC_W = 12
)
(
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire jogFwd,
  input wire jogRev,
  input wire emergencyStop,
  input wire outputBlock,
  input wire [ADC_W-1:0] analog_input_one,
  input wire [ADC_W-1:0] analog_input_two,
  input wire [15:0] maxFreq,
  input wire [7:0] overloadPct,
  input wire outputEnable,
  input wire jogActive,
  input wire jogReverse,
  input wire emergency_stop_indication,
  input wire [ADC_W-1:0] refOne,
  input wire [ADC_W-1:0] refTwo
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // bus answers
  zero_wait_a: assert property (psel |-> pready) else $error("slave inserted a wait");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h48 |-> pslverr)
    else $error("no slave error");
  mapped_ok_a: assert property (psel && paddr <= 8'h48 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("slave error on mapped word");
  refused_read_a: assert property (psel && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  // stop paths
  block_coast_a: assert property (outputBlock |=> !outputEnable)
    else $error("output still on during block");
  estop_shown_a: assert property (emergencyStop |=> emergency_stop_indication)
    else $error("stop indication missing");
  // jog start follows a jog contact
  jog_cause_a: assert property ($rose(jogActive) |-> $past(jogFwd || jogRev))
    else $error("jog without contact");
  jog_dir_a: assert property ($rose(jogReverse) |-> $past(jogRev))
    else $error("reverse jog without contact");
  // both references share one polarity
  ref_polarity_a: assert property ($past(rst_b, 2) |->
    (refOne ^ $past(analog_input_one)) == (refTwo ^ $past(analog_input_two)))
    else $error("analog references disagree");
  // duty limits travel together
  duty_limits_a: assert property (overloadPct == 8'h78 |-> maxFreq == 16'h2EE0)
    else $error("normal duty limits wrong");
  cover property (emergency_stop_indication);
  cover property (jogActive && jogReverse);
  cover property (overloadPct == 8'h78);
endmodule // rts_checker
bind rts_ramp_select rts_checker #(.TICK_CYCLES(TICK_CYCLES), .ADC_W(ADC_W)) chk (.mclk,
  .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .jogFwd, .jogRev,
  .emergencyStop, .outputBlock, .analog_input_one, .analog_input_two, .maxFreq,
  .overloadPct, .outputEnable, .jogActive, .jogReverse, .emergency_stop_indication,
  .refOne, .refTwo);

// ===== test/rts_contacts.sv
// Purpose: terminal contacts and speed feedback seen by the drive
// Assumes: bit order sel1 sel2 assigned motor run fwd rev stop block
// Notes: contacts settle one clock after the request
`timescale 1ns/1ps
module rts_contacts
(
  input wire mclk,
  input wire rst_b,
  input wire [8:0] want,
  input wire [15:0] fWant,
  output reg [8:0] pin_q,
  output reg [15:0] freq_q
);
  reg hold_q;
  // contacts follow requests, run re-close blocked after a stop
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_q <= 9'h000;
      freq_q <= 16'h0000;
      hold_q <= 1'b0;
    end
    else
    begin
      pin_q <= want;
      freq_q <= fWant;
      hold_q <= want[7] | (hold_q & (want[4] | want[7]));
      pin_q[4] <= want[4] & ~(hold_q & ~pin_q[4]);
    end
  end
endmodule // rts_contacts

// ===== test/ramp_time_select_and_stop_control_test.sv
// Purpose: self-checking bench for the ramp select block
// Assumes: zero-wait apb slave, contacts from rts_contacts
// Notes: driver queues expected words, monitor compares them
`timescale 1ns/1ps
`include "rts_map.vh"
module ramp_time_select_and_stop_control_test;
  logic mclk, rst_b, psel, penable, pwrite, probe;
  logic [1:0] pk;
  logic [7:0] paddr;
  logic [31:0] pwdata, v, err_total, cmp_count;
  logic [63:0] e;
  logic [63:0] q[$];
  logic [15:0] t[8];
  logic [15:0] fWant, maxFreq, accelTime, decelTime;
  logic [11:0] a1, a2;
  logic [8:0] want, pin;
  logic [7:0] overloadPct;
  wire [31:0] prdata, rampStep;
  wire [15:0] outFreq, freqRef;
  wire [11:0] refOne;
  wire pready, pslverr, jogActive, jogReverse, stopInd, dcBrake;
  int i;
  rts_contacts far (.mclk(mclk), .rst_b(rst_b), .want(want), .fWant(fWant), .pin_q(pin),
    .freq_q(outFreq));
  rts_ramp_select #(.TICK_CYCLES(4), .ADC_W(12)) dut (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeSel1(pin[0]),
    .timeSel2(pin[1]), .timeSelAssigned(pin[2]), .motorSwitch(pin[3]), .runCmd(pin[4]),
    .jogFwd(pin[5]), .jogRev(pin[6]), .emergencyStop(pin[7]), .outputBlock(pin[8]),
    .outFreq(outFreq), .analog_input_one(a1), .analog_input_two(a2),
    .accelTime(accelTime), .decelTime(decelTime), .freqRef(freqRef), .maxFreq(maxFreq),
    .overloadPct(overloadPct), .rampStep(rampStep), .outputEnable(), .jogActive(jogActive),
    .jogReverse(jogReverse), .emergency_stop_indication(stopInd), .dcBrake(dcBrake),
    .refOne(refOne), .refTwo());
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // monitor: oldest note against read data or probed outputs
  always @(posedge mclk)
  begin
    if (rst_b && (probe || (psel && penable && pready && !pwrite)))
    begin
      e = q.pop_front();
      v = probe ? (pk == 2'h1 ? {overloadPct, 5'h00, stopInd, jogActive, jogReverse, maxFreq}
        : pk == 2'h2 ? rampStep : pk == 2'h3 ? {freqRef, 3'h0, dcBrake, refOne}
        : {decelTime, accelTime}) : prdata;
      cmp_count = cmp_count + 1;
      if (((v ^ e[31:0]) & e[63:32]) !== 32'h0)
      begin
        err_total = err_total + 1;
        $display("[ERR] %s exp %h got %h", probe ? "outputs" : "prdata", e[31:0], v);
      end
    end
  end
  // one apb transfer, read notes its expected word
  task automatic apb(input bit wr, input [7:0] a, input [31:0] d, input [31:0] m);
    if (!wr)
      q.push_back({m, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge mclk);
    penable <= 1'b1;
    // wait for the slave, the watchdog ends a hang
    do
      @(posedge mclk);
    while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // contacts, speed and random analog, then settle
  task automatic put(input [8:0] w, input [15:0] f);
    want <= w;
    fWant <= f;
    a1 <= 12'($urandom);
    a2 <= 12'($urandom);
    repeat (4) @(posedge mclk);
  endtask
  // probe outputs one cycle
  task automatic chk(input [1:0] k, input [31:0] d, input [31:0] m);
    q.push_back({m, d});
    pk <= k;
    probe <= 1'b1;
    @(posedge mclk);
    probe <= 1'b0;
    @(posedge mclk);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    err_total = err_total + 1;
    wrap_up;
  end
  // main sequence
  initial
  begin
    {rst_b, psel, penable, pwrite, probe, pk, paddr, pwdata} = 0;
    {want, fWant, a1, a2, err_total, cmp_count} = 0;
    void'($urandom(32'hA8C28D05));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    apb(0, `RTS_ADDR_ACC1, 32'h64, 32'hFFFF);
    apb(0, `RTS_ADDR_JOGFREQ, 32'h258, 32'hFFFF);
    apb(0, 8'h4C, 32'h0, 32'hFFFFFFFF);
    for (i = 0; i < 8; i++)
    begin
      t[i] = 16'(1 + $urandom_range(59999));
      apb(1, 8'(4 * i), {16'h0, t[i]}, 0);
    end
    apb(0, `RTS_ADDR_DEC4, {16'h0, t[7]}, 32'hFFFF);
    apb(1, `RTS_ADDR_JOGACC, 32'hEA60, 0);
    apb(0, `RTS_ADDR_JOGACC, 32'hEA60, 32'hFFFF);
    apb(1, `RTS_ADDR_SWFREQ, 32'hE9FC, 0);
    for (i = 0; i < 4; i++)
    begin
      put({7'h01, i[1:0]}, 16'hE9FC);
      chk(0, {t[2 * i + 1], t[2 * i]}, 32'hFFFFFFFF);
    end
    for (i = 0; i < 2; i++)
    begin
      put(9'h00C | 9'(i), 16'h0);
      chk(0, {t[2 * i + 5], t[2 * i + 4]}, 32'hFFFFFFFF);
    end
    apb(1, `RTS_ADDR_CTRL, {29'h0, `RTS_MODE_SLV}, 0);
    put(9'h00D, 16'h0);
    chk(0, {t[3], t[2]}, 32'hFFFFFFFF);
    apb(1, `RTS_ADDR_CTRL, 32'h0, 0);
    put(9'h000, 16'hE9FB);
    chk(0, {t[1], t[0]}, 32'hFFFFFFFF);
    put(9'h000, 16'hE9FC);
    chk(0, {t[7], t[6]}, 32'hFFFFFFFF);
    repeat (80) @(posedge mclk);
    chk(2, {16'h0000, 16'hE9FC / t[7]}, 32'hFFFFFFFF);
    apb(1, `RTS_ADDR_CTRL, 32'h8, 0);
    chk(1, 32'h78002EE0, 32'hFF00FFFF);
    apb(1, `RTS_ADDR_CTRL, 32'hA, 0);
    chk(1, 32'h96003A98, 32'hFF00FFFF);
    apb(1, `RTS_ADDR_CTRL, 32'h7002, 0);
    chk(1, 32'h96001F40, 32'hFF00FFFF);
    apb(1, `RTS_ADDR_CTRL, 32'h0, 0);
    chk(1, 32'h9600E9FC, 32'hFF00FFFF);
    put(9'h020, 16'h0);
    chk(1, 32'h0, 32'h00020000);
    put(9'h000, 16'h0);
    apb(1, `RTS_ADDR_CTRL, 32'h400, 0);
    put(9'h020, 16'h0);
    chk(1, 32'h00020000, 32'h00030000);
    chk(3, {16'h0258, 4'h0, a1}, 32'hFFFF0FFF);
    put(9'h000, 16'h0);
    put(9'h040, 16'h0);
    chk(1, 32'h00030000, 32'h00030000);
    put(9'h000, 16'h0);
    apb(1, `RTS_ADDR_CTRL, 32'h10, 0);
    apb(1, `RTS_ADDR_ESTOP, 32'h0123, 0);
    put(9'h010, 16'd1000);
    chk(3, {16'hE9FC, 4'h0, ~a1}, 32'hFFFF0FFF);
    put(9'h110, 16'd1000);
    put(9'h090, 16'd1000);
    chk(1, 32'h00040000, 32'h00040000);
    chk(0, 32'h01230000, 32'hFFFF0000);
    put(9'h010, 16'h0);
    apb(0, `RTS_ADDR_STATUS, 32'h8, 32'h8);
    put(9'h000, 16'h0);
    apb(0, `RTS_ADDR_STATUS, 32'h0, 32'h8);
    // braking: start 0x100, three ticks long
    apb(1, `RTS_ADDR_DCB, 32'h00030100, 0);
    put(9'h010, 16'h0200);
    put(9'h000, 16'h0080);
    chk(3, 32'h00001000, 32'h00001000);
    repeat (30) @(posedge mclk);
    chk(3, 32'h0, 32'h00001000);
    apb(1, `RTS_ADDR_CTRL, 32'h60, 0);
    chk(3, 32'h0, 32'hFFFF0000);
    // pump preset, 50 Hz supply, asked with mode SENSORLESS_VECTOR_MODE
    apb(1, `RTS_ADDR_CTRL, 32'h8882, 0);
    apb(0, `RTS_ADDR_CTRL, 32'h880, 32'hFFFF);
    apb(0, `RTS_ADDR_STATUS, 32'h4C00, 32'hFC00);
    wrap_up;
  end
endmodule // ramp_time_select_and_stop_control_test
